// ### verilog/flash_host_pkg.sv
// Shared constants, field layouts and types of the flash command controller.
// Assumes one 125 MHz clock; every flash pin timing is counted in that clock.
package flash_host_pkg;

  // Clock period and flash bus cycle times in nanoseconds.
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_WE_LOW_NS = 50;
  localparam int T_WE_HIGH_NS = 30;
  localparam int T_OE_ACC_NS = 100;
  localparam int T_OE_HIGH_NS = 30;

  // A least time rounds up to whole cycles and is never below one cycle.
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [3:0] WE_LOW_CYC = 4'(ns_to_cyc(T_WE_LOW_NS));
  localparam logic [3:0] WE_HIGH_CYC = 4'(ns_to_cyc(T_WE_HIGH_NS));
  localparam logic [3:0] OE_ACC_CYC = 4'(ns_to_cyc(T_OE_ACC_NS));
  localparam logic [3:0] OE_HIGH_CYC = 4'(ns_to_cyc(T_OE_HIGH_NS));

  // Register byte offsets on the AXI4-Lite port.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_RDATA = 8'h18;
  localparam logic [7:0] OFS_BUF = 8'h40;

  // Control, configuration and status field positions.
  localparam int CTRL_ALT_PROG = 3;
  localparam int CFG_WP = 0;
  localparam int CFG_BYTE_N = 1;
  localparam int CFG_RESET = 2;
  localparam int STAT_BUSY = 16;
  localparam int STAT_SUSP = 17;
  localparam int STAT_REFUSED = 18;
  localparam int STAT_COUNT_ERR = 19;
  localparam int STAT_STS_PIN = 20;
  localparam logic [2:0] CFG_RESET_VAL = 3'h2;

  // Device command codes and status bit positions.
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_PROG = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_BUF_PROG = 8'he8;
  localparam logic [4:0] MAX_COUNT_X8 = 5'h1f;
  localparam logic [4:0] MAX_COUNT_X16 = 5'h0f;
  localparam int SR_READY = 7;
  localparam int SR_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int XSR_BUF_AVAIL = 7;

  localparam int FADDR_W = 21;

  // Operation codes written to the control register.
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_WRITE = 3'h1,
    OP_READ = 3'h2,
    OP_CHIP_ERASE = 3'h3,
    OP_PROGRAM = 3'h4,
    OP_BUF_PROGRAM = 3'h5
  } op_t;

  // Every pin that the controller drives toward the flash.
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic wp;
    logic rp_n;
    logic byte_n;
    logic [FADDR_W-1:0] addr;
    logic [15:0] dout;
    logic doe;
  } flash_out_t;

endpackage

// ### verilog/flash_host.sv
// Host-side command controller for an asynchronous parallel flash memory.
// Assumes the flash pins are synchronous to CLK_I and an AXI4-Lite master drives the bus.
`timescale 1ns/1ps

// Notes on behaviour
// - Chip erase is a setup write followed by confirm D0H; blocks erase in order.
// - Single program is setup 40H or 10H, then one address and data write.
// - Host writes E8H and repeats it until the buffer-available flag reads one.
// - Host then writes count minus one, at most 1FH bytes or 0FH words.
// - Host writes start address and data pairs in range, then confirm D0H; the controller sends addr_reg plus index with no block check.
// - Host holds write-protect, reset and width-select levels during a suspend.
module flash_host #(
  parameter int BUF_DEPTH = 32,
  parameter logic [7:0] CHIP_ERASE_SETUP = 8'h00
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [7:0] S_AXI_ARADDR_I,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output flash_host_pkg::flash_out_t FLASH_O,
  input wire logic [15:0] FD_I,
  input wire logic STS_I
);
  import flash_host_pkg::*;

  typedef enum {B_IDLE, B_WLOW, B_WHIGH, B_RLOW, B_RHIGH} bus_t;
  typedef enum {SQ_IDLE, SQ_CONFIRM, SQ_PDATA, SQ_XSR, SQ_XSR_CHK, SQ_BDATA, SQ_POLL,
                SQ_POLL_CHK, SQ_END} seq_t;

  bus_t bus;
  seq_t seq;
  op_t op;
  logic [3:0] bcnt;
  logic [15:0] rd_latch;
  logic [4:0] idx;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] rd_mux;
  logic [3:0] ctrl;
  logic [FADDR_W-1:0] addr_reg;
  logic [15:0] data_reg;
  logic [4:0] count_reg;
  logic [2:0] cfg;
  logic [7:0] dev_status;
  logic [7:0] ext_status;
  logic [15:0] rdata_reg;
  logic suspended;
  logic refused;
  logic count_err;
  logic [15:0] buf_mem [BUF_DEPTH];
  logic start;
  logic [4:0] max_count;
  logic buf_blocked;

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Address decode shared by the read and write paths.
  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && ((a <= OFS_RDATA) ||
           ((a >= OFS_BUF) && (32'(a) < 32'(OFS_BUF) + 4 * BUF_DEPTH)));
  endfunction

  function automatic logic [4:0] buf_index(input logic [7:0] a);
    return 5'((a - OFS_BUF) >> 2);
  endfunction

  // A write is performed once both address and data are held and no response is pending.
  assign do_write = !S_AXI_AWREADY_O && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
  assign start = do_write && (aw_addr == OFS_CTRL) && w_strb[0] && (w_data[2:0] != 3'h0);
  assign max_count = cfg[CFG_BYTE_N] ? MAX_COUNT_X16 : MAX_COUNT_X8;
  // Buffered programs are held back while either error flag from the last status is set.
  assign buf_blocked = dev_status[SR_PROG_ERR] || dev_status[SR_ERASE_ERR];

  // AXI4-Lite write channels; address and data are taken in either order.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O <= 1'b1;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= 2'h0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_addr <= S_AXI_AWADDR_I;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (do_write) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= is_mapped(aw_addr) ? 2'h0 : 2'h2;
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O <= 1'b1;
      end
    end
  end

  // Read data selection; unmapped addresses read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (S_AXI_ARADDR_I)
      OFS_CTRL: rd_mux = {28'h0, ctrl};
      OFS_ADDR: rd_mux = 32'(addr_reg);
      OFS_DATA: rd_mux = {16'h0000, data_reg};
      OFS_COUNT: rd_mux = {27'h0, count_reg};
      OFS_CFG: rd_mux = {29'h0, cfg};
      OFS_STAT: rd_mux = {11'h0, STS_I, count_err, refused, suspended, seq != SQ_IDLE,
                          ext_status, dev_status};
      OFS_RDATA: rd_mux = {16'h0000, rdata_reg};
      default: begin
        if (is_mapped(S_AXI_ARADDR_I) && (S_AXI_ARADDR_I >= OFS_BUF)) begin
          rd_mux = {16'h0000, buf_mem[buf_index(S_AXI_ARADDR_I)]};
        end
      end
    endcase
  end

  // AXI4-Lite read channel; one read is answered the cycle after its address is taken.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= 2'h0;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= rd_mux;
      S_AXI_RRESP_O <= is_mapped(S_AXI_ARADDR_I) ? 2'h0 : 2'h2;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_ARREADY_O <= 1'b1;
    end
  end

  // Software-written operands. Width-select, write-protect and reset are frozen while the
  // erase is suspended, because changing them then would corrupt the paused erase.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ctrl <= 4'h0;
      addr_reg <= '0;
      data_reg <= 16'h0000;
      count_reg <= 5'h00;
      cfg <= CFG_RESET_VAL;
    end else if (do_write) begin
      case (aw_addr)
        OFS_CTRL: ctrl <= 4'(merge(32'(ctrl), w_data, w_strb));
        OFS_ADDR: addr_reg <= FADDR_W'(merge(32'(addr_reg), w_data, w_strb));
        OFS_DATA: data_reg <= 16'(merge(32'(data_reg), w_data, w_strb));
        OFS_COUNT: count_reg <= 5'(merge(32'(count_reg), w_data, w_strb));
        OFS_CFG: begin
          if (!suspended) begin
            cfg <= 3'(merge(32'(cfg), w_data, w_strb));
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Buffer of program data, one entry per word or byte.
  always_ff @(posedge CLK_I) begin
    if (do_write && is_mapped(aw_addr) && (aw_addr >= OFS_BUF)) begin
      buf_mem[buf_index(aw_addr)] <= 16'(merge({16'h0000, buf_mem[buf_index(aw_addr)]},
                                               w_data, w_strb));
    end
  end

  // Sticky refusal and count errors; a new event wins over a clear in the same cycle.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      refused <= 1'b0;
      count_err <= 1'b0;
    end else begin
      if (do_write && (aw_addr == OFS_STAT) && w_strb[2]) begin
        if (w_data[STAT_REFUSED]) begin
          refused <= 1'b0;
        end
        if (w_data[STAT_COUNT_ERR]) begin
          count_err <= 1'b0;
        end
      end
      if (start && ((seq != SQ_IDLE) || (w_data[2:0] == 3'(OP_CHIP_ERASE) && suspended) ||
          (w_data[2:0] == 3'(OP_BUF_PROGRAM) && buf_blocked))) begin
        refused <= 1'b1;
      end
      if (start && (seq == SQ_IDLE) && (w_data[2:0] == 3'(OP_BUF_PROGRAM)) && !buf_blocked &&
          (count_reg > max_count)) begin
        count_err <= 1'b1;
      end
    end
  end

  // Start one flash bus cycle; write when we is high, otherwise read.
  task automatic issue(input logic we, input logic [FADDR_W-1:0] a, input logic [15:0] d);
    FLASH_O.addr <= a;
    FLASH_O.dout <= d;
    FLASH_O.doe <= we;
    FLASH_O.ce_n <= 1'b0;
    FLASH_O.we_n <= !we;
    FLASH_O.oe_n <= we;
    bcnt <= we ? WE_LOW_CYC : OE_ACC_CYC;
    bus <= we ? B_WLOW : B_RLOW;
  endtask

  // Command sequencer and flash bus cycle engine. The host polls each erase and program until
  // it finishes, so a suspend can never be sent in the middle of a chip erase.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      bus <= B_IDLE;
      seq <= SQ_IDLE;
      op <= OP_NONE;
      bcnt <= 4'h0;
      idx <= 5'h00;
      rd_latch <= 16'h0000;
      dev_status <= 8'h80;
      ext_status <= 8'h00;
      rdata_reg <= 16'h0000;
      suspended <= 1'b0;
      FLASH_O <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, wp: 1'b0, rp_n: 1'b1, byte_n: 1'b1,
                   addr: '0, dout: 16'h0000, doe: 1'b0};
    end else begin
      FLASH_O.wp <= cfg[CFG_WP];
      FLASH_O.byte_n <= cfg[CFG_BYTE_N];
      FLASH_O.rp_n <= !cfg[CFG_RESET];
      case (bus)
        B_WLOW, B_RLOW: begin
          if (bcnt > 4'h1) begin
            bcnt <= bcnt - 4'h1;
          end else begin
            if (bus == B_RLOW) begin
              rd_latch <= FD_I;
            end
            FLASH_O.we_n <= 1'b1; // Data is captured by the flash on this rising edge.
            FLASH_O.oe_n <= 1'b1;
            FLASH_O.ce_n <= 1'b1;
            bcnt <= (bus == B_WLOW) ? WE_HIGH_CYC : OE_HIGH_CYC;
            bus <= (bus == B_WLOW) ? B_WHIGH : B_RHIGH;
          end
        end
        B_WHIGH, B_RHIGH: begin
          FLASH_O.doe <= 1'b0;
          if (bcnt > 4'h1) begin
            bcnt <= bcnt - 4'h1;
          end else begin
            bus <= B_IDLE;
          end
        end
        default: begin
          case (seq)
            SQ_IDLE: begin
              if (start) begin
                op <= op_t'(w_data[2:0]);
                case (op_t'(w_data[2:0]))
                  OP_WRITE: begin
                    issue(1'b1, addr_reg, data_reg);
                    seq <= SQ_END;
                  end
                  OP_READ: begin
                    issue(1'b0, addr_reg, 16'h0000);
                    seq <= SQ_END;
                  end
                  OP_CHIP_ERASE: begin
                    if (!suspended) begin
                      issue(1'b1, addr_reg, {8'h00, CHIP_ERASE_SETUP});
                      seq <= SQ_CONFIRM;
                    end
                  end
                  OP_PROGRAM: begin
                    issue(1'b1, addr_reg,
                          {8'h00, w_data[CTRL_ALT_PROG] ? CMD_PROG_ALT : CMD_PROG});
                    seq <= SQ_PDATA;
                  end
                  OP_BUF_PROGRAM: begin
                    if (!buf_blocked && (count_reg <= max_count)) begin
                      issue(1'b1, addr_reg, {8'h00, CMD_BUF_PROG});
                      seq <= SQ_XSR;
                    end
                  end
                  default: begin
                  end
                endcase
              end
            end
            SQ_CONFIRM: begin
              issue(1'b1, addr_reg, {8'h00, CMD_CONFIRM});
              seq <= SQ_POLL;
            end
            SQ_PDATA: begin
              issue(1'b1, addr_reg, data_reg);
              seq <= SQ_POLL;
            end
            SQ_XSR: begin
              issue(1'b0, addr_reg, 16'h0000);
              seq <= SQ_XSR_CHK;
            end
            SQ_XSR_CHK: begin
              ext_status <= rd_latch[7:0];
              if (rd_latch[XSR_BUF_AVAIL]) begin
                issue(1'b1, addr_reg, {11'h000, count_reg});
                idx <= 5'h00;
                seq <= SQ_BDATA;
              end else begin
                issue(1'b1, addr_reg, {8'h00, CMD_BUF_PROG});
                seq <= SQ_XSR;
              end
            end
            SQ_BDATA: begin
              issue(1'b1, addr_reg + FADDR_W'(idx), buf_mem[idx]);
              idx <= idx + 5'h01;
              seq <= (idx == count_reg) ? SQ_CONFIRM : SQ_BDATA;
            end
            SQ_POLL: begin
              issue(1'b0, addr_reg, 16'h0000);
              seq <= SQ_POLL_CHK;
            end
            SQ_POLL_CHK: begin
              dev_status <= rd_latch[7:0];
              if (rd_latch[SR_READY]) begin
                suspended <= rd_latch[SR_SUSP];
                seq <= SQ_IDLE;
              end else begin
                issue(1'b0, addr_reg, 16'h0000);
              end
            end
            SQ_END: begin
              if (op == OP_READ) begin
                rdata_reg <= rd_latch;
                dev_status <= rd_latch[7:0];
                suspended <= rd_latch[SR_READY] & rd_latch[SR_SUSP];
              end
              seq <= SQ_IDLE;
            end
            default: seq <= SQ_IDLE;
          endcase
        end
      endcase
    end
  end

endmodule // flash_host

// ### verif/flash_host_sva.sv
// Port checker for the flash command controller: bus handshakes and flash strobes.
// Assumes it is bound to flash_host and sees only that module's ports.
`timescale 1ns/1ps
module flash_host_sva (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire flash_host_pkg::flash_out_t FLASH_O
);
  import flash_host_pkg::*;
  // Everything runs on the one clock; reset masks all checks but the reset one.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // A write strobe is seven low cycles with address and data held still.
  sequence wr_strobe;
    (!FLASH_O.we_n && !FLASH_O.ce_n && FLASH_O.doe && $stable(FLASH_O.addr)
      && $stable(FLASH_O.dout))[*6] ##1 FLASH_O.we_n;
  endsequence
  sequence rd_hold;
    !FLASH_O.oe_n && !FLASH_O.ce_n && $stable(FLASH_O.addr);
  endsequence
  // A read strobe is thirteen low cycles, split so no repetition exceeds eight.
  sequence rd_strobe;
    rd_hold[*8] ##1 rd_hold[*4] ##1 FLASH_O.oe_n;
  endsequence
  bresp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
  rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read data dropped");
  wr_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
    && S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O) else $error("write answer late");
  rd_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O) else $error("read answer late");
  we_frame_a: assert property ($fell(FLASH_O.we_n) |=> wr_strobe)
    else $error("write strobe malformed");
  oe_frame_a: assert property ($fell(FLASH_O.oe_n) |=> rd_strobe)
    else $error("read strobe malformed");
  we_recover_a: assert property ($rose(FLASH_O.we_n) |-> FLASH_O.we_n[*4])
    else $error("write recovery too short");
  bus_clash_a: assert property (!FLASH_O.oe_n |-> FLASH_O.we_n && !FLASH_O.doe)
    else $error("data bus driven during read");
  rst_state_a: assert property (disable iff (1'b0) !RST_N_I |=> S_AXI_AWREADY_O
    && !S_AXI_BVALID_O && FLASH_O.we_n && FLASH_O.rp_n) else $error("reset state wrong");
endmodule // flash_host_sva

bind flash_host flash_host_sva i_flash_host_sva (.*);

// ### verif/flash_dev_model.sv
// Behavioural flash device: command decoder, status, buffered program, memory.
// Assumes the controller strobes are synchronous to clk_i; data bus resolved here.
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [7:0] ERASE_SETUP = 8'h30
) (
  input wire logic clk_i,
  input wire flash_host_pkg::flash_out_t f_i,
  input wire logic vpp_low_i,
  input wire logic locked_i,
  output logic [15:0] fd_o,
  output logic sts_o
);
  import flash_host_pkg::*;
  logic [15:0] mem [int];
  logic [36:0] q [$];
  logic [7:0] sr = 8'h00;
  logic [7:0] setup_seen = 8'h00;
  logic [20:0] wa = '0;
  logic [15:0] wd = '0;
  logic [15:0] last = '0;
  logic [15:0] rdv;
  logic wprev = 1'b1;
  logic xok = 1'b0;
  int mode = 0, seq = 0, busy = 0, cnt = 0, xsr_wait = 0, e8_seen = 0, erase_cnt = 0;
  // Reads show status until a read-array command; ready only once busy runs out.
  always_comb begin
    rdv = (mode == 0) ? (mem.exists(int'(f_i.addr)) ? mem[int'(f_i.addr)] : 16'hffff)
      : (mode == 1) ? {8'h00, busy == 0, sr[6:0]} : {8'h00, xok, 7'h00};
  end
  // A released bus shows a changing pattern so a stale value never passes as data.
  assign fd_o = f_i.doe ? f_i.dout : (!f_i.ce_n && !f_i.oe_n) ? rdv : ~last;
  assign sts_o = (busy == 0);
  // Commands are taken on the rising write strobe with the address and data latched.
  always @(posedge clk_i) begin
    last <= fd_o;
    wprev <= f_i.we_n;
    if (busy > 0) busy <= busy - 1;
    if (!f_i.we_n) begin
      wa <= f_i.addr;
      wd <= f_i.dout;
    end
    if (!wprev && f_i.we_n) cmd(wa, wd);
  end
  task automatic cmd(input logic [20:0] a, input logic [15:0] d);
    case (seq)
      1, 5: begin
        mode = 1;
        if (seq == 5 && d[7:0] != CMD_CONFIRM) sr[5:4] = 2'b11;
        else if (vpp_low_i) sr[4:3] = 2'b11;
        else if (locked_i && !f_i.wp) sr[4:1] = 4'b1001;
        else if (seq == 1) mem[int'(a)] = d;
        else begin
          foreach (q[i]) if (q[i][36:32] == q[0][36:32]) mem[int'(q[i][36:16])] = q[i][15:0];
          if (q[0][36:32] != q[$][36:32]) sr[5:4] = 2'b11;
        end
        if (sr[4] == 1'b0) busy <= 20;
        seq = 0;
      end
      2: begin
        seq = 0;
        if (d[7:0] != CMD_CONFIRM) sr[5:4] = 2'b11;
        else if (vpp_low_i) sr[5:3] = 3'b101;
        else begin
          if (f_i.wp || !locked_i) mem.delete();
          erase_cnt++;
          busy <= 60;
        end
      end
      3: begin
        cnt = int'(d[4:0]);
        q.delete();
        mode = 1;
        seq = 4;
      end
      4: begin
        q.push_back({a, d});
        if (q.size() > cnt) seq = 5;
      end
      default: case (d[7:0])
        CMD_PROG, CMD_PROG_ALT: begin
          setup_seen = d[7:0];
          seq = 1;
        end
        ERASE_SETUP: seq = 2;
        CMD_BUF_PROG: begin
          e8_seen++;
          mode = 2;
          xok = (xsr_wait == 0) && !sr[4] && !sr[5];
          if (xsr_wait > 0) xsr_wait--;
          if (xok) seq = 3;
        end
        CMD_CONFIRM: begin
          sr[6] = 1'b0; // Erase resume.
          mode = 1;
        end
        8'h50: sr[5:1] = 5'h00;
        8'hff: mode = 0;
        default: mode = 1; // Suspend is ignored: only chip erase runs here.
      endcase
    endcase
  endtask
endmodule // flash_dev_model

// ### verif/tb_top.sv
// Self-checking bench for the flash command controller over AXI4-Lite.
// Assumes flash_dev_model stands at the flash pins; one 125 MHz clock.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module tb_top;
  import flash_host_pkg::*;
  localparam logic [7:0] ERASE_CODE = 8'h30;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, vpp_low = 0, locked = 0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wdat = '0, rdat, s;
  logic awr, wrdy, bv, arr, rv, sts;
  logic [1:0] bresp, rresp, r;
  logic [15:0] fd;
  flash_out_t fo;
  int fail_count = 0, total_checks = 0, cyc = 0;
  flash_host #(.CHIP_ERASE_SETUP(ERASE_CODE)) i_flash_host (.CLK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wdat), .S_AXI_WSTRB_I(4'hf), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bry), .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry), .S_AXI_RDATA_O(rdat),
    .S_AXI_RRESP_O(rresp), .FLASH_O(fo), .FD_I(fd), .STS_I(sts));
  flash_dev_model #(.ERASE_SETUP(ERASE_CODE)) i_flash_dev_model (.clk_i(clk), .f_i(fo),
    .vpp_low_i(vpp_low), .locked_i(locked), .fd_o(fd), .sts_o(sts));
  // Clock, and a hang guard sized well above the longest expected run.
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      close_out();
    end
  end
  // Write: both channels offered together, each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ad, dd;
    @(posedge clk);
    awv <= 1; wv <= 1; bry <= 1; awa <= a; wdat <= d; ad = 0; dd = 0;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awr === 1'b1) begin ad = 1; awv <= 0; end
      if (!dd && wrdy === 1'b1) begin dd = 1; wv <= 0; end
    end
    while (bv !== 1'b1) @(posedge clk);
    rs = bresp; bry <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    arv <= 1; rry <= 1; ara <= a;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    while (rv !== 1'b1) @(posedge clk);
    d = rdat; rs = rresp; rry <= 0;
  endtask
  // Start an operation and poll until the controller is no longer busy.
  task automatic op(input logic [3:0] c);
    wr(OFS_CTRL, {28'h0, c}, r);
    do rd(OFS_STAT, s, r); while (s[STAT_BUSY] !== 1'b0);
  endtask
  task automatic dcmd(input logic [7:0] c);
    wr(OFS_DATA, {24'h0, c}, r);
    op(4'h1);
  endtask
  task automatic t_regs();
    rd(OFS_CFG, s, r); `CHK("cfg reset", {29'h0, CFG_RESET_VAL}, s)
    rd(8'h3c, s, r); `CHK("unmapped resp", 2'h2, r)
    wr(8'h3c, 32'h1, r); `CHK("unmapped write", 2'h2, r)
    rd(OFS_STAT, s, r); `CHK("status reset", 8'h80, s[7:0])
    wr(OFS_CFG, 32'h7, r); rd(OFS_CFG, s, r);
    `CHK("flash pins", 3'b101, {fo.wp, fo.rp_n, fo.byte_n})
    wr(OFS_CFG, {29'h0, CFG_RESET_VAL}, r);
    $display("register test done");
  endtask
  task automatic t_prog();
    for (int k = 0; k < 2; k++) begin
      wr(OFS_ADDR, 32'h100 + k, r);
      wr(OFS_DATA, 32'h1230 + k, r);
      op({k[0], 3'h4});
      `CHK("program word", 16'h1230 + 16'(k), i_flash_dev_model.mem[32'h100 + k])
      `CHK("setup code", k ? CMD_PROG_ALT : CMD_PROG, i_flash_dev_model.setup_seen)
    end
    // Supply low, then locked block with protect low; each blocks later buffers.
    wr(OFS_ADDR, 32'h300, r);
    for (int k = 0; k < 2; k++) begin
      vpp_low <= (k == 0); locked <= (k == 1);
      op(4'h4);
      `CHK("error flags", k ? 8'h12 : 8'h18, s[7:0] & 8'h1e)
      op(4'h5);
      `CHK("buffer refused", 1'b1, s[STAT_REFUSED])
      wr(OFS_STAT, 32'h000c0000, r);
      dcmd(8'h50);
      op(4'h2); // The held status must be refreshed, or later buffers stay blocked.
    end
    `CHK("memory kept", 1'b0, i_flash_dev_model.mem.exists(32'h300))
    vpp_low <= 0; locked <= 0;
    $display("program test done");
  endtask
  task automatic t_buf();
    i_flash_dev_model.xsr_wait = 2;
    wr(OFS_COUNT, 32'h1, r); wr(OFS_BUF, 32'haaaa, r); wr(8'h44, 32'h5555, r);
    wr(OFS_ADDR, 32'h200, r);
    op(4'h5);
    `CHK("buffer word 0", 16'haaaa, i_flash_dev_model.mem[32'h200])
    `CHK("buffer word 1", 16'h5555, i_flash_dev_model.mem[32'h201])
    `CHK("setup retries", 3, i_flash_dev_model.e8_seen)
    wr(OFS_ADDR, 32'h1ffff, r);
    op(4'h5);
    `CHK("boundary flags", 8'h30, s[7:0] & 8'h30)
    `CHK("before boundary", 16'haaaa, i_flash_dev_model.mem[32'h1ffff])
    `CHK("past boundary", 0, i_flash_dev_model.mem.exists(32'h20000))
    dcmd(8'h50);
    op(4'h2);
    wr(OFS_COUNT, 32'h10, r);
    op(4'h5);
    `CHK("count too big", 1'b1, s[STAT_COUNT_ERR])
    $display("buffer test done");
  endtask
  task automatic t_erase();
    vpp_low <= 1;
    op(4'h3);
    `CHK("low supply flags", 2'b11, {s[5], s[3]})
    `CHK("nothing erased", 0, i_flash_dev_model.erase_cnt)
    vpp_low <= 0;
    dcmd(8'h50);
    op(4'h3);
    `CHK("erase done", 1, i_flash_dev_model.erase_cnt)
    `CHK("memory blank", 0, i_flash_dev_model.mem.size())
    `CHK("ready flag", 1'b1, s[SR_READY])
    `CHK("status pin", 1'b1, s[STAT_STS_PIN])
    $display("erase test done");
  endtask
  // The model is put into a paused block erase; chip erase itself is never suspended.
  task automatic t_susp();
    i_flash_dev_model.sr[6] = 1'b1;
    wr(OFS_ADDR, 32'h400, r);
    op(4'h4);
    `CHK("suspend seen", 1'b1, s[STAT_SUSP])
    op(4'h3);
    `CHK("erase refused", 1'b1, s[STAT_REFUSED])
    wr(OFS_CFG, 32'h0, r);
    dcmd(CMD_CONFIRM);
    op(4'h2);
    `CHK("resumed", 1'b0, s[STAT_SUSP])
    rd(OFS_CFG, s, r);
    `CHK("cfg frozen", {29'h0, CFG_RESET_VAL}, s)
    $display("suspend test done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    t_regs();
    t_prog();
    t_buf();
    t_erase();
    t_susp();
    close_out();
  end
endmodule // tb_top
